// [core/mtc_defines.vh]
// Register map, field positions, reset values and timing of the tx/test block
`ifndef MTC_DEFINES_VH
`define MTC_DEFINES_VH

`define MTC_ADDR_W 12
`define MTC_TX_CONFIG_COPY_ADDR 12'h108
`define MTC_TEST_CONTROL_ADDR 12'h118
`define MTC_BUS_STATUS_ADDR 12'h138
`define MTC_REFLECT_ADDR 12'h13C
`define MTC_TX_COMMAND_ADDR 12'h144
`define MTC_TX_LENGTH_ADDR 12'h146

`define MTC_TEST_CONTROL_RESET 16'h0019
`define MTC_TEST_CONTROL_WMASK 16'h4E80
`define MTC_TEST_CONTROL_ID 6'h19
`define MTC_BUS_STATUS_ID 6'h18
`define MTC_REFLECT_ID 6'h1C
`define MTC_TX_COMMAND_ID 6'h09
`define MTC_TX_COMMAND_WMASK 16'h33C0
`define MTC_TX_COMMAND_RESET 16'h0009

`define MTC_TC_LINK_TEST_DISABLE 7
`define MTC_TC_ENDEC_LOOP 9
`define MTC_TC_AUI_LOOP 10
`define MTC_TC_BACKOFF_DISABLE 11
`define MTC_TC_FULL_DUPLEX 14

`define MTC_BS_BID_ERROR 7
`define MTC_BS_READY_NOW 8

`define MTC_CMD_START_LO 6
`define MTC_CMD_START_HI 7
`define MTC_CMD_FORCE 8
`define MTC_CMD_ONE_COLL 9
`define MTC_CMD_CRC_INHIBIT 12
`define MTC_CMD_PAD_DISABLE 13

`define MTC_START_5 2'h0
`define MTC_START_381 2'h1
`define MTC_START_1021 2'h2
`define MTC_START_ALL 2'h3
`define MTC_BYTES_5 11'h005
`define MTC_BYTES_381 11'h17D
`define MTC_BYTES_1021 11'h3FD

`define MTC_LEN_MIN 16'h0003
`define MTC_LEN_MAX_CRC 16'h05EA
`define MTC_LEN_MAX 16'h05EE
`define MTC_PAD_LEN 11'h03C
`define MTC_COLL_LIMIT_ONE 5'h01
`define MTC_COLL_LIMIT_NORMAL 5'h10

`define MTC_CLK_HZ 200000000
`define MTC_REFLECT_HZ 10000000
`define MTC_FORCE_BIT_TIMES 64

`endif

// [core/mtc_reflect_timer.v]
// Cable reflectometer counter ticking at the 10 MHz rate
`timescale 1ns/1ps
`include "mtc_defines.vh"
module mtc_reflect_timer (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire stop,
    input wire clear,
    output wire [9:0] count
);
    localparam [31:0] DIV = `MTC_CLK_HZ / `MTC_REFLECT_HZ;
    localparam [4:0] DIV_LAST = DIV[4:0] - 5'h01;

    reg [4:0] div_q;
    reg run_q;
    reg [9:0] count_q;
    wire tick;

    assign tick = (div_q == DIV_LAST);
    assign count = count_q;

    // Divider restarts with each transmission so the first period is whole
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 5'h00;
        end else if (start || tick) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    // (RQ13) run from start to error
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (stop) begin
            run_q <= 1'b0;
        end else if (start) begin
            run_q <= 1'b1;
        end
    end

    // (RQ14) clear on read
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 10'h000;
        end else if (start) begin
            count_q <= 10'h000;
        end else if (clear) begin
            // A tick in the read cycle is kept, not lost
            count_q <= (run_q && tick && !stop) ? 10'h001 : 10'h000;
        end else if (run_q && tick && !stop && count_q != 10'h3FF) begin
            count_q <= count_q + 10'h001;
        end
    end
endmodule

// [core/mtc_top.v]
// Transmit command, bid status, test control and reflectometer registers
//
// What this block does
// (RQ1) Bus status reads fixed id 011000 in its low six bits.
// (RQ2) Bid error set for frames above 1514 bytes with CRC appended.
// (RQ3) Bid error set, frame refused above 1518 bytes; short frames never flag.
// (RQ4) Ready-now status bit is polled only and raises no interrupt.
// (RQ5) Test control reads fixed id 011001 in its low six bits.
// (RQ6) No link and no override: block traffic, send link pulses only.
// (RQ7) Encoder loopback feeds encoder into decoder, line drivers kept out.
// (RQ8) Attachment loopback lets reception run while transmitting on that port.
// (RQ9) Backoff disable skips backoff, waiting only for inter-packet gap.
// (RQ10) Full duplex ignores carrier sense on the twisted-pair port.
// (RQ11) Host sets full duplex before twisted-pair loopback tests.
// (RQ12) Test control resets to 0019h unless loaded from config memory.
// (RQ13) Reflect counter counts 10 MHz periods from start until error.
// (RQ14) Reading reflect register clears count; low id bits stay 011100.
// (RQ15) Command location write-only; last word readable at the copy offset.
// (RQ16) No frame is sent when transmit length is below 3.
// (RQ17) Two-bit threshold picks when the MAC begins transmitting.
// (RQ18) Force with new command flushes queue, aborts frame with bad CRC.
// (RQ19) One-collision mode aborts after first collision, else after 16.
// (RQ20) CRC inhibit drops the frame check sequence.
// (RQ21) Padding on: short frames padded to 60, CRC unless inhibited.
// (RQ22) Padding off: runts sent unpadded, CRC only if not inhibited.
// (RQ23) Threshold codes 0..3 mean 5, 381, 1021 bytes, whole frame.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "mtc_defines.vh"
module mtc_top (
    input wire ref_clk,
    input wire reset_n,
    input wire [11:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [15:0] reg_rdata,
    input wire cfg_load,
    input wire [15:0] cfg_word,
    input wire link_good,
    input wire carrier_sense,
    input wire aui_select,
    input wire tx_space_ok,
    input wire [10:0] tx_bytes_buffered,
    input wire tx_frame_complete,
    input wire mac_tx_active,
    input wire mac_collision,
    input wire aui_tx_begin,
    input wire aui_loss_of_carrier,
    input wire encoder_out,
    input wire tp_rx_pin,
    input wire aui_rx_pin,
    output wire traffic_enable,
    output wire link_pulse_only,
    output wire rx_enable,
    output wire tp_line_enable,
    output wire aui_line_enable,
    output wire decoder_in,
    output wire carrier_sense_used,
    output wire backoff_enable,
    output wire tx_start,
    output wire [10:0] tx_frame_length,
    output wire tx_crc_append,
    output wire tx_flush,
    output wire tx_abort_bad_crc,
    output wire tx_coll_abort
);
    reg rst_s1_q;
    reg rst_s2_q;
    wire rst_n;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Line inputs: three stages, change taken when stages two and three agree
    wire [1:0] pin_raw;
    wire [1:0] pin_f;
    assign pin_raw = {aui_rx_pin, tp_rx_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg f_q;
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    f_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        f_q <= s3_q;
                    end
                end
            end
            assign pin_f[gi] = f_q;
        end
    endgenerate

    function thresh_met;
        input [1:0] code;
        input [10:0] bytes;
        input complete;
        begin
            case (code)
                `MTC_START_5: thresh_met = complete ||
                    (bytes >= `MTC_BYTES_5);
                `MTC_START_381: thresh_met = complete ||
                    (bytes >= `MTC_BYTES_381);
                `MTC_START_1021: thresh_met = complete ||
                    (bytes >= `MTC_BYTES_1021);
                default: thresh_met = complete;
            endcase
        end
    endfunction

    wire wr_cmd;
    wire wr_len;
    wire wr_tc;
    wire rd_tdr;
    assign wr_cmd = reg_wr && (reg_addr == `MTC_TX_COMMAND_ADDR);
    assign wr_len = reg_wr && (reg_addr == `MTC_TX_LENGTH_ADDR);
    assign wr_tc = reg_wr && (reg_addr == `MTC_TEST_CONTROL_ADDR);
    assign rd_tdr = reg_rd && (reg_addr == `MTC_REFLECT_ADDR);

    reg [15:0] tc_q;
    reg [15:0] cmd_q;
    reg bid_err_q;
    reg ready_now_q;
    reg pending_q;
    reg [15:0] rdata_q;

    wire lt_dis;
    wire endec_loop;
    wire aui_loop;
    wire full_duplex_enable;
    wire allowed;
    assign lt_dis = tc_q[`MTC_TC_LINK_TEST_DISABLE];
    assign endec_loop = tc_q[`MTC_TC_ENDEC_LOOP];
    assign aui_loop = tc_q[`MTC_TC_AUI_LOOP];
    assign full_duplex_enable = tc_q[`MTC_TC_FULL_DUPLEX];
    // (RQ6) override only matters without link
    assign allowed = link_good || lt_dis;

    // (RQ12) reset default, config load after release
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tc_q <= `MTC_TEST_CONTROL_RESET;
        end else if (wr_tc) begin
            tc_q <= (reg_wdata & `MTC_TEST_CONTROL_WMASK) |
                {10'h000, `MTC_TEST_CONTROL_ID};
        end else if (cfg_load) begin
            tc_q <= (cfg_word & `MTC_TEST_CONTROL_WMASK) |
                {10'h000, `MTC_TEST_CONTROL_ID};
        end
    end

    // (RQ15) keep last command word for the copy
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= `MTC_TX_COMMAND_RESET;
        end else if (wr_cmd) begin
            cmd_q <= (reg_wdata & `MTC_TX_COMMAND_WMASK) |
                {10'h000, `MTC_TX_COMMAND_ID};
        end
    end

    wire crc_inh;
    wire pad_dis;
    wire one_coll;
    wire len_short;
    wire len_long;
    assign crc_inh = cmd_q[`MTC_CMD_CRC_INHIBIT];
    assign pad_dis = cmd_q[`MTC_CMD_PAD_DISABLE];
    assign one_coll = cmd_q[`MTC_CMD_ONE_COLL];
    // (RQ16) too short: dropped quietly
    assign len_short = (reg_wdata < `MTC_LEN_MIN);
    // (RQ2) (RQ3) oversize limits
    assign len_long = (reg_wdata > `MTC_LEN_MAX) ||
        (!crc_inh && reg_wdata > `MTC_LEN_MAX_CRC);

    // Set wins over the clear from a new command
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bid_err_q <= 1'b0;
        end else if (wr_len && len_long) begin
            bid_err_q <= 1'b1;
        end else if (wr_cmd) begin
            bid_err_q <= 1'b0;
        end
    end

    reg start_q;
    reg flush_q;
    reg abort_q;
    reg coll_abort_q;
    reg crc_app_q;
    reg [10:0] flen_q;
    reg [1:0] thr_q;
    reg [4:0] coll_lim_q;
    reg [4:0] coll_cnt_q;
    reg force_go;

    always @* begin
        force_go = wr_cmd && reg_wdata[`MTC_CMD_FORCE];
    end

    // Bid accepted on the length write that follows the command
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_q <= 1'b0;
            start_q <= 1'b0;
            flush_q <= 1'b0;
            abort_q <= 1'b0;
            crc_app_q <= 1'b0;
            flen_q <= 11'h000;
            thr_q <= 2'h0;
            coll_lim_q <= `MTC_COLL_LIMIT_NORMAL;
        end else begin
            start_q <= 1'b0;
            // (RQ18) flush queue and cut the running frame at once
            flush_q <= force_go;
            abort_q <= force_go && mac_tx_active;
            if (force_go) begin
                pending_q <= 1'b0;
            end else if (wr_len && !len_short && !len_long) begin
                pending_q <= 1'b1;
                // (RQ20) CRC only when not inhibited
                crc_app_q <= !crc_inh;
                // (RQ21) (RQ22) pad to 60 unless disabled
                flen_q <= (!pad_dis && reg_wdata[10:0] < `MTC_PAD_LEN) ?
                    `MTC_PAD_LEN : reg_wdata[10:0];
                thr_q <= cmd_q[`MTC_CMD_START_HI:`MTC_CMD_START_LO];
                // (RQ19) collision limit per frame
                coll_lim_q <= one_coll ? `MTC_COLL_LIMIT_ONE :
                    `MTC_COLL_LIMIT_NORMAL;
            end else if (pending_q && allowed && !mac_tx_active &&
                    // (RQ17) (RQ23) start threshold
                    thresh_met(thr_q, tx_bytes_buffered,
                        tx_frame_complete)) begin
                pending_q <= 1'b0;
                start_q <= 1'b1;
            end
        end
    end

    // (RQ19) count collisions of the current frame
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coll_cnt_q <= 5'h00;
            coll_abort_q <= 1'b0;
        end else begin
            coll_abort_q <= 1'b0;
            if (start_q) begin
                coll_cnt_q <= 5'h00;
            end else if (mac_tx_active && mac_collision &&
                    coll_cnt_q != coll_lim_q) begin
                coll_cnt_q <= coll_cnt_q + 5'h01;
                coll_abort_q <= (coll_cnt_q + 5'h01 == coll_lim_q);
            end
        end
    end

    // (RQ4) polled status only, no interrupt path
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_now_q <= 1'b0;
        end else begin
            ready_now_q <= tx_space_ok && !pending_q;
        end
    end

    wire [9:0] tdr_count;
    mtc_reflect_timer u_reflect (
        .clk(ref_clk),
        .rst_n(rst_n),
        .start(aui_tx_begin),
        .stop((mac_collision && aui_select) || aui_loss_of_carrier),
        .clear(rd_tdr),
        .count(tdr_count)
    );

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                // (RQ5) id in low bits
                `MTC_TEST_CONTROL_ADDR: rdata_q <= tc_q;
                // (RQ15) command copy readable here only
                `MTC_TX_CONFIG_COPY_ADDR: rdata_q <= cmd_q;
                // (RQ1) fixed id plus status
                `MTC_BUS_STATUS_ADDR: rdata_q <= {7'h00, ready_now_q,
                    bid_err_q, 1'b0, `MTC_BUS_STATUS_ID};
                // (RQ14) id stays fixed
                `MTC_REFLECT_ADDR: rdata_q <= {tdr_count,
                    `MTC_REFLECT_ID};
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    reg traffic_q;
    reg lp_only_q;
    reg rx_en_q;
    reg tp_en_q;
    reg aui_en_q;
    reg dec_q;
    reg cs_q;
    reg backoff_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            traffic_q <= 1'b0;
            lp_only_q <= 1'b1;
            rx_en_q <= 1'b0;
            tp_en_q <= 1'b0;
            aui_en_q <= 1'b0;
            dec_q <= 1'b0;
            cs_q <= 1'b0;
            backoff_q <= 1'b1;
        end else begin
            // (RQ6) gate traffic, link pulses only
            traffic_q <= allowed;
            lp_only_q <= !allowed;
            // (RQ8) half-duplex attachment blocks rx unless looped
            rx_en_q <= allowed && !(aui_select && mac_tx_active &&
                !aui_loop);
            // (RQ7) line drivers out during encoder loopback
            tp_en_q <= allowed && !endec_loop && !aui_select;
            aui_en_q <= !endec_loop && aui_select;
            dec_q <= endec_loop ? encoder_out :
                (aui_select ? pin_f[1] : pin_f[0]);
            // (RQ10) full duplex ignores carrier sense
            cs_q <= carrier_sense && !(full_duplex_enable && !aui_select);
            // (RQ9) backoff disable
            backoff_q <= !tc_q[`MTC_TC_BACKOFF_DISABLE];
        end
    end

    assign reg_rdata = rdata_q;
    assign traffic_enable = traffic_q;
    assign link_pulse_only = lp_only_q;
    assign rx_enable = rx_en_q;
    assign tp_line_enable = tp_en_q;
    assign aui_line_enable = aui_en_q;
    assign decoder_in = dec_q;
    assign carrier_sense_used = cs_q;
    assign backoff_enable = backoff_q;
    assign tx_start = start_q;
    assign tx_frame_length = flen_q;
    assign tx_crc_append = crc_app_q;
    assign tx_flush = flush_q;
    assign tx_abort_bad_crc = abort_q;
    assign tx_coll_abort = coll_abort_q;
endmodule

// [sim/mtc_checker.sv]
// Port-level assertions for the tx command and test block
`timescale 1ns/1ps
module mtc_checker (
    input wire ref_clk,
    input wire reset_n,
    input wire [11:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire link_good,
    input wire mac_tx_active,
    input wire mac_collision,
    input wire traffic_enable,
    input wire link_pulse_only,
    input wire tx_start,
    input wire [10:0] tx_frame_length,
    input wire tx_crc_append,
    input wire tx_flush,
    input wire tx_abort_bad_crc,
    input wire tx_coll_abort
);
    reg [2:0] up_q;
    reg [15:0] cmd_q;
    reg ok_q;
    reg crc_q;
    reg [10:0] len_q;
    reg [4:0] lim_q;
    reg [4:0] coll_q;
    // Internal reset lags the pin by two edges
    wire live = up_q[2];
    wire [15:0] w = reg_wdata;
    wire lw = reg_wr && reg_addr == 12'h146;
    wire rt = live && reg_rd && reg_addr == 12'h13C;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            up_q <= 3'h0;
            cmd_q <= 16'h0000;
            ok_q <= 1'b0;
            coll_q <= 5'h00;
        end else begin
            if (!live)
                up_q <= up_q + 3'h1;
            if (reg_wr && reg_addr == 12'h144)
                cmd_q <= w;
            if (lw)
                ok_q <= w > 16'h0002 && w < 16'h05EF &&
                    (cmd_q[12] || w < 16'h05EB);
            else if (tx_start)
                ok_q <= 1'b0;
            if (tx_start)
                coll_q <= 5'h00;
            else if (mac_collision && mac_tx_active && coll_q != 5'h1F)
                coll_q <= coll_q + 5'h01;
        end
    end
    always @(posedge ref_clk) begin
        if (lw) begin
            crc_q <= !cmd_q[12];
            lim_q <= cmd_q[9] ? 5'h01 : 5'h10;
            len_q <= (cmd_q[13] || w[10:0] > 11'h03B) ? w[10:0] : 11'h03C;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_ID_STATUS:
    assert property (live && reg_rd && reg_addr == 12'h138 |=>
        reg_rdata[6:0] == 7'h18 && reg_rdata[15:9] == 7'h00)
        else $error("status id bits wrong");
    AST_ID_TEST:
    assert property (live && reg_rd && reg_addr == 12'h118 |=>
        reg_rdata[6:0] == 7'h19) else $error("test control id wrong");
    AST_TDR_ID:
    assert property (rt |=> reg_rdata[5:0] == 6'h1C)
        else $error("reflect id wrong");
    AST_TDR_CLEAR:
    assert property (rt ##1 rt |=> reg_rdata[15:6] <= 10'h001)
        else $error("reflect count not cleared by read");
    AST_CMD_WO:
    assert property (live && reg_rd && reg_addr == 12'h144 |=>
        reg_rdata == 16'h0000) else $error("command location readable");
    AST_LINK:
    assert property (live && link_good |=> traffic_enable &&
        !link_pulse_only) else $error("traffic blocked with link good");
    AST_START_OK:
    assert property (tx_start |-> ok_q)
        else $error("start without valid length");
    AST_START_FMT:
    assert property (tx_start |-> tx_frame_length == len_q &&
        tx_crc_append == crc_q) else $error("frame length or crc wrong");
    AST_FORCE:
    assert property (live && reg_wr && reg_addr == 12'h144 && w[8] |=>
        tx_flush && tx_abort_bad_crc == $past(mac_tx_active))
        else $error("force did not flush or abort");
    AST_COLL:
    assert property (tx_coll_abort |-> coll_q == lim_q)
        else $error("collision abort at wrong count");
endmodule
bind mtc_top mtc_checker u_chk (.*);

// [sim/mtc_mac_model.sv]
// Behavioural MAC transmit engine on the far side of the block
`timescale 1ns/1ps
module mtc_mac_model (
    input wire ref_clk,
    input wire reset_n,
    input wire tx_start,
    input wire tx_abort_bad_crc,
    input wire tx_coll_abort,
    input wire [4:0] coll_n,
    input wire [7:0] dur,
    input wire hold,
    output wire mac_tx_active,
    output reg mac_collision,
    output reg aui_tx_begin
);
    reg act_q;
    reg [7:0] t_q;
    reg [4:0] c_q;
    // Collisions every fourth cycle, up to the asked number
    wire hit = act_q && t_q[1:0] == 2'h3 && c_q < coll_n;
    // Hold keeps the engine busy without any frame
    assign mac_tx_active = act_q | hold;
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            act_q <= 1'b0;
            t_q <= 8'h00;
            c_q <= 5'h00;
            mac_collision <= 1'b0;
            aui_tx_begin <= 1'b0;
        end else begin
            aui_tx_begin <= tx_start;
            mac_collision <= hit;
            if (hit)
                c_q <= c_q + 5'h01;
            if (tx_start) begin
                act_q <= 1'b1;
                t_q <= 8'h00;
                c_q <= 5'h00;
            end else if (act_q) begin
                t_q <= t_q + 8'h01;
                if (t_q == dur || tx_abort_bad_crc || tx_coll_abort)
                    act_q <= 1'b0;
            end
        end
    end
endmodule

// [sim/mac_tx_command_and_test_control_tb.sv]
// Self-checking bench for the tx command and test block
`timescale 1ns/1ps
module mac_tx_command_and_test_control_tb;
    reg ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [15:0] reg_wdata = 16'h0000, cfg_word = 16'h0000;
    reg cfg_load = 1'b0, link_good = 1'b0, carrier_sense = 1'b0;
    reg aui_select = 1'b0, tx_space_ok = 1'b1, tx_frame_complete = 1'b1;
    reg [10:0] tx_bytes_buffered = 11'h7FF;
    reg aui_loss_of_carrier = 1'b0, encoder_out = 1'b0, hold = 1'b0;
    reg tp_rx_pin = 1'b0, aui_rx_pin = 1'b0;
    reg [4:0] coll_n = 5'h00;
    reg [7:0] dur = 8'h08;
    wire mac_tx_active, mac_collision, aui_tx_begin;
    wire [15:0] reg_rdata;
    wire traffic_enable, link_pulse_only, rx_enable, tp_line_enable;
    wire aui_line_enable, decoder_in, carrier_sense_used, backoff_enable;
    wire tx_start, tx_crc_append, tx_flush, tx_abort_bad_crc, tx_coll_abort;
    wire [10:0] tx_frame_length;
    reg [15:0] mismatches = 16'h0, checked = 16'h0, starts = 16'h0;
    reg [15:0] aborts = 16'h0, s0, a0, v, n, d;
    reg [31:0] r;
    integer seed = 44210, i, k;
    localparam [167:0] RT = {12'h118, 16'h0019, 12'h138, 16'h0118,
        12'h13C, 16'h001C, 12'h108, 16'h0009, 12'h144, 16'h0000,
        12'h200, 16'h0000};
    localparam [127:0] CL = {16'h05EF, 16'h05EE, 16'h05EB, 16'h05EA,
        16'h003C, 16'h003B, 16'h0003, 16'h0002};
    mtc_top u_mtc_top (.*);
    mtc_mac_model u_mtc_mac_model (.*);
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        tp_rx_pin <= ~tp_rx_pin;
        aui_rx_pin <= tp_rx_pin;
        if (tx_start === 1'b1)
            starts <= starts + 16'h1;
        if (tx_coll_abort === 1'b1)
            aborts <= aborts + 16'h1;
    end
    function bad(input [15:0] c, input [15:0] l);
        bad = l > 16'h05EE || (l > 16'h05EA && !c[12]);
    endfunction
    function [10:0] thr(input [1:0] c);
        thr = c == 2'h0 ? 11'h005 : c == 2'h1 ? 11'h17D :
            c == 2'h2 ? 11'h3FD : 11'h7FF;
    endfunction
    function [6:0] exp_io(input [15:0] t, input lk, au, cs, ac);
        reg al;
        begin
            al = lk | t[7];
            exp_io = {al, !al, al & !(au & ac & !t[10]), al & !t[9] & !au,
                !t[9] & au, cs & !(t[14] & !au), !t[11]};
        end
    endfunction
    task chk(input [15:0] s, input [15:0] e, input [8*12:1] nm);
        begin
            checked = checked + 16'h1;
            if (s !== e) begin
                mismatches = mismatches + 16'h1;
                $display("[ERR] %0s exp %h seen %h", nm, e, s);
            end
        end
    endtask
    task wr(input [11:0] a, input [15:0] x);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= x;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, output [15:0] x);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1 x = reg_rdata;
        end
    endtask
    task bid(input [15:0] c, input [15:0] l);
        begin
            s0 = starts;
            wr(12'h144, c);
            wr(12'h146, l);
        end
    endtask
    task idle;
        for (k = 0; k < 300 && mac_tx_active === 1'b1; k = k + 1)
            @(posedge ref_clk);
    endtask
    task give_verdict;
        begin
            if (mismatches == 16'h0 && checked > 16'h0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #100000;
        mismatches = mismatches + 16'h1;
        give_verdict;
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (i = 0; i < 6; i = i + 1) begin
            rd(RT[i*28+16 +: 12], d);
            chk(d, RT[i*28 +: 16], "reset read");
        end
        @(posedge ref_clk);
        tx_space_ok <= 1'b0;
        rd(12'h138, d);
        chk(d, 16'h0018, "not ready");
        for (i = 0; i < 24; i = i + 1) begin
            @(posedge ref_clk);
            r = $random(seed);
            v = r[15:0];
            if (v[9] && !r[17])
                v[14] = 1'b1;
            {encoder_out, hold, carrier_sense, aui_select} <= r[20:17];
            link_good <= r[16];
            if (i[0]) begin
                wr(12'h118, v);
            end else begin
                cfg_word <= v;
                cfg_load <= 1'b1;
                @(posedge ref_clk);
                cfg_load <= 1'b0;
            end
            repeat (8) @(posedge ref_clk);
            #1 chk({9'h0, traffic_enable, link_pulse_only, rx_enable,
                tp_line_enable, aui_line_enable, carrier_sense_used,
                backoff_enable}, {9'h0, exp_io(v, r[16], r[17], r[18],
                r[19])}, "line modes");
            chk({15'h0, decoder_in}, {15'h0, v[9] & r[20]}, "decoder");
            rd(12'h118, d);
            chk(d, (v & 16'h4E80) | 16'h0019, "test ctl");
        end
        @(posedge ref_clk);
        {hold, aui_select, tx_space_ok, link_good} <= 4'h7;
        wr(12'h118, 16'h0000);
        for (i = 0; i < 14; i = i + 1) begin
            r = $random(seed);
            v = r[31:16] & 16'h32C0;
            n = i < 8 ? CL[i*16 +: 16] : 16'h3 + {5'h0, r[10:0]} % 16'd1516;
            bid(v, n);
            repeat (12) @(posedge ref_clk);
            chk(starts - s0, {15'h0, n > 16'h2 && !bad(v, n)}, "sent");
            rd(12'h138, d);
            chk(d, 16'h0118 | {8'h0, bad(v, n), 7'h0}, "bid err");
            rd(12'h108, d);
            chk(d, (v & 16'h33C0) | 16'h0009, "cmd copy");
            idle;
        end
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge ref_clk);
            tx_frame_complete <= 1'b0;
            tx_bytes_buffered <= thr(i[1:0]) - 11'h1;
            bid({8'h0, i[1:0], 6'h0}, 16'h05DC);
            repeat (12) @(posedge ref_clk);
            chk(starts - s0, 16'h0, "early start");
            tx_frame_complete <= i == 3;
            tx_bytes_buffered <= thr(i[1:0]);
            repeat (6) @(posedge ref_clk);
            chk(starts - s0, 16'h1, "threshold");
            idle;
        end
        @(posedge ref_clk);
        dur <= 8'hC8;
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge ref_clk);
            coll_n <= i == 0 ? 5'h03 : 5'h0F + {4'h0, i[0]};
            a0 = aborts;
            bid(i == 0 ? 16'h0200 : 16'h0000, 16'h0064);
            repeat (4) @(posedge ref_clk);
            idle;
            chk(aborts - a0, {15'h0, i != 2}, "coll abort");
        end
        @(posedge ref_clk);
        coll_n <= 5'h00;
        hold <= 1'b1;
        bid(16'h0000, 16'h0064);
        rd(12'h138, d);
        chk(d, 16'h0018, "pending");
        wr(12'h144, 16'h0100);
        @(posedge ref_clk);
        hold <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk(starts - s0, 16'h0, "flushed");
        rd(12'h138, d);
        chk(d, 16'h0118, "ready again");
        @(posedge ref_clk);
        aui_select <= 1'b1;
        rd(12'h13C, d);
        bid(16'h0000, 16'h00C8);
        repeat (150) @(posedge ref_clk);
        aui_loss_of_carrier <= 1'b1;
        @(posedge ref_clk);
        aui_loss_of_carrier <= 1'b0;
        reg_addr <= 12'h13C;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        #1 chk(reg_rdata, {10'h007, 6'h1C}, "reflect");
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 16'h001C, "reflect clr");
        idle;
        give_verdict;
    end
endmodule
